// [verilog/asq_pkg.sv]
// Constants and types shared by the converter sequencer files.
package asq_pkg;
    // Register indices; the byte address is four times the index.
    localparam logic [7:0] IDX_RESULT = 8'h1E;
    localparam logic [7:0] IDX_CTRL   = 8'h1F;
    localparam logic [7:0] IDX_PCFG   = 8'h9F;
    localparam logic [7:0] IDX_IRQ    = 8'h20;
    localparam logic [7:0] IDX_DIR    = 8'h21;
    localparam logic [7:0] IDX_PORT   = 8'h22;
    // Field positions in the control register.
    localparam int CTL_ON   = 0;
    localparam int CTL_GO   = 2;
    localparam int CTL_CH   = 3;
    localparam int CTL_CLK  = 6;
    // Field positions in the interrupt register.
    localparam int IRQ_FLAG = 0;
    localparam int IRQ_EN   = 1;
    localparam int IRQ_GLB  = 2;
    // Values after reset.
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [2:0] RST_PCFG = 3'h0;
    localparam logic [7:0] RST_DIR  = 8'hFF;
    // Clock select codes.
    localparam logic [1:0] CLK_D2  = 2'h0;
    localparam logic [1:0] CLK_D8  = 2'h1;
    localparam logic [1:0] CLK_D32 = 2'h2;
    localparam logic [1:0] CLK_RC  = 2'h3;
    // Timing in half bit periods and core clock cycles.
    localparam logic [4:0] CONV_HALVES = 5'h13;
    localparam logic [4:0] HOLD_HALVES = 5'h04;
    localparam logic [4:0] INSTR_CYC   = 5'h04;
    // Sequencer states.
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_DELAY = 2'b01,
        ST_CONV  = 2'b10,
        ST_HOLD  = 2'b11
    } asq_state_e;
    // Core clock cycles per half bit period for one select code.
    function automatic logic [4:0] half_div(input logic [1:0] sel);
        case (sel)
            CLK_D2:  half_div = 5'h01;
            CLK_D8:  half_div = 5'h04;
            default: half_div = 5'h10;
        endcase
    endfunction
    // Pins in analog use for one pin role code, channel order.
    function automatic logic [7:0] analog_mask(input logic [2:0] cfg);
        case (cfg)
            3'h0, 3'h1: analog_mask = 8'hFF;
            3'h2, 3'h3: analog_mask = 8'h1F;
            3'h4, 3'h5: analog_mask = 8'h0B;
            default:    analog_mask = 8'h00;
        endcase
    endfunction
endpackage

// [verilog/asq_tad_if.sv]
// Link between the sequencer and its bit period timer.
`timescale 1ns/1ps
interface asq_tad_if;
    logic [1:0] sel;
    logic       run;
    logic       half_tick;
    modport gen (input sel, input run, output half_tick);
    modport seq (output sel, output run, input half_tick);
endinterface

// [verilog/asq_tad_gen.sv]
// Bit period timer: one pulse per half bit conversion period.
`timescale 1ns/1ps
module asq_tad_gen #(
    parameter int DIV_W = 5
) (
    // Clock and reset.
    input  wire logic mclk_in,
    input  wire logic rst_in,
    // Internal RC oscillator strobe.
    input  wire logic rc_tick_in,
    // Sequencer side.
    asq_tad_if.gen    tad
);
    logic [DIV_W-1:0] div_r;
    logic [DIV_W-1:0] lim;
    initial
    begin
        if (DIV_W < 5) $error("DIV_W too small for the slowest divider");
    end
    assign lim = DIV_W'(asq_pkg::half_div(tad.sel));
    // The RC strobe replaces the divided core clock when selected.
    assign tad.half_tick = tad.run &&
        ((tad.sel == asq_pkg::CLK_RC) ? rc_tick_in : (div_r == lim - 1'b1));
    // Divider restarts whenever the timer is idle, so phase starts clean.
    always_ff @(posedge mclk_in)
    begin
        if (rst_in || !tad.run || tad.half_tick)
            div_r <= '0;
        else
            div_r <= div_r + 1'b1;
    end
endmodule

// [verilog/asq_top.sv]
// Converter sequencer: registers, pin roles and conversion control.
// How it works
// - Pin role code chooses analog pins and the reference source.
// - Upper five bits of the pin role register read as zero.
// - A conversion lasts nine and a half bit periods.
// - Bit period is 2, 8 or 32 clocks, or the RC clock.
// - Two bit periods pass after a conversion before new acquisition.
// - Analog pins read low in the port data register.
// - Clearing start aborts and leaves the result untouched.
// - After abort, wait two bit periods, then acquire again.
// - With RC clock, wait one instruction cycle before converting.
// - Completion clears start and loads the result.
// - Completion in sleep wakes if enabled, else powers down.
// - Sleep with a non RC clock aborts and powers down.
// - Reset restores registers, disables, aborts, makes pins inputs.
// - Result register is not reset.
// - Completion seen by polling start or by the interrupt.
`timescale 1ns/1ps
module asq_top (
    // Clock and reset.
    input  wire logic       mclk_in,
    input  wire logic       rst_in,
    // AHB-Lite slave.
    input  wire logic       hsel_in,
    input  wire logic [31:0] haddr_in,
    input  wire logic [1:0] htrans_in,
    input  wire logic       hwrite_in,
    input  wire logic [2:0] hsize_in,
    input  wire logic [31:0] hwdata_in,
    input  wire logic       hready_in,
    output logic      [31:0] hrdata_out,
    output logic            hreadyout_out,
    output logic            hresp_out,
    // Core and analog side.
    input  wire logic       sleep_in,
    input  wire logic       rc_tick_in,
    input  wire logic       comp_in,
    input  wire logic [7:0] pin_level_in,
    output logic      [7:0] sar_code_out,
    output logic      [2:0] channel_out,
    output logic      [7:0] pin_dir_out,
    output logic      [7:0] port_read_out,
    output logic            vref_ext_out,
    output logic            sample_out,
    output logic            powered_out,
    output logic            irq_out,
    output logic            wake_out
);
    asq_tad_if tad ();
    asq_pkg::asq_state_e state_r;
    asq_pkg::asq_state_e state_nxt;
    logic [7:0]  ctrl_r;
    logic [2:0]  pcfg_r;
    logic [7:0]  dir_r;
    logic [2:0]  irq_r;
    logic [7:0]  result_r;
    logic [7:0]  sar_r;
    logic [7:0]  sar_nxt;
    logic [4:0]  cnt_r;
    logic [7:0]  aidx_r;
    logic        wpend_r;
    logic        rpend_r;
    logic [31:0] rdata_r;
    logic        take;
    logic        wr_now;
    logic [7:0]  wdat;
    logic        wr_ctrl;
    logic        go_set;
    logic        go_clr;
    logic        busy;
    logic        slp_abort;
    logic        abort;
    logic        done_p;
    logic        is_rc;
    logic [2:0]  bit_ix;
    logic [8:0]  stay_cyc_r;

    // Bus address phase is taken when the slave is selected and ready.
    assign take   = hsel_in && hready_in && htrans_in[1];
    assign wr_now = wpend_r;
    assign wdat   = hwdata_in[7:0];
    assign wr_ctrl = wr_now && aidx_r == asq_pkg::IDX_CTRL;
    assign hreadyout_out = !rpend_r;
    assign hresp_out     = 1'b0;
    assign hrdata_out    = rdata_r;

    // Latch address phase; unaligned addresses map to nothing.
    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            aidx_r  <= 8'h00;
            wpend_r <= 1'b0;
            rpend_r <= 1'b0;
        end
        else
        begin
            wpend_r <= take && hwrite_in;
            rpend_r <= take && !hwrite_in;
            if (take)
                aidx_r <= (haddr_in[1:0] == 2'h0 && haddr_in[31:10] == '0)
                          ? haddr_in[9:2] : 8'hFF;
        end
    end

    // Read data is sampled in the one wait cycle of a read.
    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
            rdata_r <= 32'h0000_0000;
        else if (rpend_r)
        begin
            case (aidx_r)
                asq_pkg::IDX_RESULT: rdata_r <= {24'h0, result_r};
                asq_pkg::IDX_CTRL:   rdata_r <= {24'h0, ctrl_r};
                asq_pkg::IDX_PCFG:   rdata_r <= {29'h0, pcfg_r};
                asq_pkg::IDX_IRQ:    rdata_r <= {29'h0, irq_r};
                asq_pkg::IDX_DIR:    rdata_r <= {24'h0, dir_r};
                asq_pkg::IDX_PORT:   rdata_r <= {24'h0, port_read_out};
                default:             rdata_r <= 32'h0000_0000;
            endcase
        end
    end

    // Pin roles and reference selection.
    assign port_read_out = pin_level_in & ~asq_pkg::analog_mask(pcfg_r);
    assign vref_ext_out  = pcfg_r[0] && pcfg_r[2:1] != 2'h3;
    assign pin_dir_out   = dir_r;
    assign channel_out   = ctrl_r[asq_pkg::CTL_CH +: 3];

    // Pin role register; only three bits are stored.
    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
            pcfg_r <= asq_pkg::RST_PCFG;
        else if (wr_now && aidx_r == asq_pkg::IDX_PCFG)
            pcfg_r <= wdat[2:0];
    end

    // Direction register; reset makes every analog capable pin an input.
    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
            dir_r <= asq_pkg::RST_DIR;
        else if (wr_now && aidx_r == asq_pkg::IDX_DIR)
            dir_r <= wdat;
    end

    // Sequencer controls derived from writes and sleep.
    assign is_rc  = ctrl_r[asq_pkg::CTL_CLK +: 2] == asq_pkg::CLK_RC;
    assign busy   = state_r == asq_pkg::ST_DELAY || state_r == asq_pkg::ST_CONV;
    // Start needs the converter already on from an earlier write.
    assign go_set = wr_ctrl && wdat[asq_pkg::CTL_GO] && ctrl_r[asq_pkg::CTL_ON];
    assign go_clr = wr_ctrl && !wdat[asq_pkg::CTL_GO] && ctrl_r[asq_pkg::CTL_GO];
    assign slp_abort = sleep_in && !is_rc && busy;
    assign abort  = (go_clr && busy) || slp_abort;
    assign done_p = state_r == asq_pkg::ST_CONV && tad.half_tick &&
                    cnt_r == asq_pkg::CONV_HALVES - 5'h01;

    // Control register; completion and aborts clear the start bit.
    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
            ctrl_r <= asq_pkg::RST_CTRL;
        else
        begin
            if (wr_ctrl)
            begin
                ctrl_r <= {wdat[7:3], go_set, 1'b0, wdat[asq_pkg::CTL_ON]};
                if (!wdat[asq_pkg::CTL_GO] && !slp_abort && !done_p)
                    ctrl_r[asq_pkg::CTL_GO] <= 1'b0;
                else if (done_p || slp_abort)
                    ctrl_r[asq_pkg::CTL_GO] <= 1'b0;
                else
                    ctrl_r[asq_pkg::CTL_GO] <= go_set || ctrl_r[asq_pkg::CTL_GO];
            end
            else if (done_p || slp_abort || !ctrl_r[asq_pkg::CTL_ON])
                ctrl_r[asq_pkg::CTL_GO] <= 1'b0;
        end
    end

    // Timer link: run while converting or waiting after a conversion.
    assign tad.sel = ctrl_r[asq_pkg::CTL_CLK +: 2];
    assign tad.run = (state_r == asq_pkg::ST_CONV && !abort) ||
                     state_r == asq_pkg::ST_HOLD; // Abort restarts the divider

    asq_tad_gen #(
        .DIV_W (5)
    ) u_tad (
        .mclk_in    (mclk_in),
        .rst_in     (rst_in),
        .rc_tick_in (rc_tick_in),
        .tad        (tad.gen)
    );

    // Next state of the conversion sequencer.
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            asq_pkg::ST_IDLE:
            begin
                if (ctrl_r[asq_pkg::CTL_GO] && ctrl_r[asq_pkg::CTL_ON] && !go_clr)
                    state_nxt = is_rc ? asq_pkg::ST_DELAY : asq_pkg::ST_CONV;
            end
            asq_pkg::ST_DELAY:
            begin
                if (abort)
                    state_nxt = asq_pkg::ST_HOLD;
                else if (cnt_r == asq_pkg::INSTR_CYC - 5'h01)
                    state_nxt = asq_pkg::ST_CONV;
            end
            asq_pkg::ST_CONV:
            begin
                if (done_p || abort)
                    state_nxt = asq_pkg::ST_HOLD;
            end
            asq_pkg::ST_HOLD:
            begin
                if (tad.half_tick && cnt_r == asq_pkg::HOLD_HALVES - 5'h01)
                    state_nxt = asq_pkg::ST_IDLE;
            end
            default: state_nxt = asq_pkg::ST_IDLE;
        endcase
        if (!ctrl_r[asq_pkg::CTL_ON])
            state_nxt = asq_pkg::ST_IDLE;
    end

    // State register and shared counter of cycles or half periods.
    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            state_r <= asq_pkg::ST_IDLE;
            cnt_r   <= 5'h00;
        end
        else
        begin
            state_r <= state_nxt;
            if (state_nxt != state_r)
                cnt_r <= 5'h00;
            else if (state_r == asq_pkg::ST_DELAY || tad.half_tick)
                cnt_r <= cnt_r + 5'h01;
        end
    end

    // Successive approximation: decide one bit every bit period.
    assign bit_ix = 3'(3'h7 - cnt_r[3:1]);
    always_comb
    begin
        sar_nxt = sar_r;
        if (state_r == asq_pkg::ST_CONV && tad.half_tick &&
            cnt_r[0] && cnt_r < 5'h10)
        begin
            sar_nxt[bit_ix] = comp_in;
            if (bit_ix != 3'h0)
                sar_nxt[bit_ix - 3'h1] = 1'b1;
        end
    end

    // Trial code restarts at mid scale when a conversion begins.
    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
            sar_r <= 8'h00;
        else if (state_r != asq_pkg::ST_CONV && state_nxt == asq_pkg::ST_CONV)
            sar_r <= 8'h80;
        else
            sar_r <= sar_nxt;
    end
    assign sar_code_out = sar_r;
    assign sample_out = ctrl_r[asq_pkg::CTL_ON] && state_r == asq_pkg::ST_IDLE;

    // Result is loaded on completion or by a bus write and is never reset.
    always_ff @(posedge mclk_in)
    begin
        if (done_p)
            result_r <= sar_nxt;
        else if (wr_now && aidx_r == asq_pkg::IDX_RESULT)
            result_r <= wdat;
    end

    // Done flag: completion wins over a software clear in the same cycle.
    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
            irq_r <= 3'h0;
        else
        begin
            if (wr_now && aidx_r == asq_pkg::IDX_IRQ)
                irq_r <= wdat[2:0];
            if (done_p)
                irq_r[asq_pkg::IRQ_FLAG] <= 1'b1;
        end
    end

    // Interrupt request, wake and power state.
    assign irq_out = irq_r[asq_pkg::IRQ_FLAG] && irq_r[asq_pkg::IRQ_EN] &&
                     irq_r[asq_pkg::IRQ_GLB];
    assign wake_out = sleep_in && irq_out;
    // In sleep only an RC conversion keeps the converter alive.
    assign powered_out = ctrl_r[asq_pkg::CTL_ON] &&
                         (!sleep_in || (is_rc && state_r != asq_pkg::ST_IDLE));

    // Core cycles spent in the present state, for the timing checks only.
    always_ff @(posedge mclk_in)
    begin
        if (rst_in || state_nxt != state_r)
            stay_cyc_r <= 9'h000;
        else
            stay_cyc_r <= stay_cyc_r + 9'h001;
    end

    // Checks.
    a_cfg_reads_zero: assert property (@(posedge mclk_in) disable iff (rst_in)
        (rpend_r && aidx_r == asq_pkg::IDX_PCFG) |=> hrdata_out[31:3] == '0)
        else $error("pin role register upper bits not zero");
    a_all_digital: assert property (@(posedge mclk_in) disable iff (rst_in)
        (pcfg_r[2:1] == 2'h3) |-> (port_read_out == pin_level_in && !vref_ext_out))
        else $error("digital pin role not honoured");
    a_analog_low: assert property (@(posedge mclk_in) disable iff (rst_in)
        (pcfg_r == 3'h0) |-> port_read_out == 8'h00)
        else $error("analog pin read not low");
    a_conv_done_len: assert property (@(posedge mclk_in) disable iff (rst_in)
        (done_p && !is_rc)
        |-> stay_cyc_r == 9'(19 * asq_pkg::half_div(tad.sel)) - 9'h001)
        else $error("conversion length wrong");
    a_div_eight: assert property (@(posedge mclk_in) disable iff (rst_in)
        (tad.half_tick && tad.sel == asq_pkg::CLK_D8 && state_r == asq_pkg::ST_CONV
         && !done_p && !abort) |=> !tad.half_tick [*3] ##1 tad.half_tick)
        else $error("eight clock period not kept");
    a_hold_after: assert property (@(posedge mclk_in) disable iff (rst_in)
        (state_r == asq_pkg::ST_HOLD && state_nxt == asq_pkg::ST_IDLE
         && ctrl_r[asq_pkg::CTL_ON] && !is_rc)
        |-> stay_cyc_r == 9'(4 * asq_pkg::half_div(tad.sel)) - 9'h001)
        else $error("hold shorter than two bit periods");
    a_abort_keeps: assert property (@(posedge mclk_in) disable iff (rst_in)
        (abort && !done_p && !(wr_now && aidx_r == asq_pkg::IDX_RESULT))
        |=> (result_r == $past(result_r) && state_r == asq_pkg::ST_HOLD))
        else $error("abort changed result");
    a_rc_delay: assert property (@(posedge mclk_in) disable iff (rst_in)
        (state_r == asq_pkg::ST_IDLE && state_nxt == asq_pkg::ST_DELAY)
        ##1 (state_r == asq_pkg::ST_DELAY && !abort && ctrl_r[asq_pkg::CTL_ON]) [*4]
        |=> state_r == asq_pkg::ST_CONV)
        else $error("RC start delay wrong");
    a_done_result: assert property (@(posedge mclk_in) disable iff (rst_in)
        done_p |=> (!ctrl_r[asq_pkg::CTL_GO] && result_r == $past(sar_nxt)
                    && irq_r[asq_pkg::IRQ_FLAG]))
        else $error("completion effects missing");
    a_sleep_abort: assert property (@(posedge mclk_in) disable iff (rst_in)
        (slp_abort && ctrl_r[asq_pkg::CTL_ON]) |=> (state_r == asq_pkg::ST_HOLD
        && !ctrl_r[asq_pkg::CTL_GO] && !powered_out && ctrl_r[asq_pkg::CTL_ON])
        || !sleep_in)
        else $error("sleep did not abort");
    c_done: cover property (@(posedge mclk_in) disable iff (rst_in) done_p);
    c_abort: cover property (@(posedge mclk_in) disable iff (rst_in) go_clr && busy);
    c_rc_sleep: cover property (@(posedge mclk_in) disable iff (rst_in)
        done_p && sleep_in && is_rc);
endmodule

// [tb/adc_sequencer_port_config_tb_top.sv]
// Self-checking bench for the converter sequencer and its pin role register.
`timescale 1ns/1ps
module adc_sequencer_port_config_tb_top;
    // Bus, core side and bookkeeping signals.
    logic        mclk_in;
    logic        rst_in;
    logic        hsel_in;
    logic [31:0] haddr_in;
    logic [1:0]  htrans_in;
    logic        hwrite_in;
    logic [31:0] hwdata_in;
    logic [31:0] hrdata_out;
    logic        hreadyout_out;
    logic        sleep_in;
    logic        rc_tick_in = 1'b0;
    logic [7:0]  target;
    logic [7:0]  pin_lv = 8'hFF;
    logic [7:0]  sar_code_out;
    logic [7:0]  pin_dir_out;
    logic [7:0]  port_read_out;
    logic        vref_ext_out;
    logic        sample_out;
    logic        powered_out;
    logic        irq_out;
    logic        wake_out;
    logic [31:0] rd;
    logic [4:0]  rc_cnt = 5'h00;
    int          err_total;
    int          num_checks;
    int          cycles = 0;
    // Acquisition wait of 16 us at 25 ns a cycle.
    localparam int ACQ_CYC = 640;
    // The comparator answers as if the analog input held the target code.
    asq_top u_dut (
        .mclk_in       (mclk_in),
        .rst_in        (rst_in),
        .hsel_in       (hsel_in),
        .haddr_in      (haddr_in),
        .htrans_in     (htrans_in),
        .hwrite_in     (hwrite_in),
        .hsize_in      (3'h2),
        .hwdata_in     (hwdata_in),
        .hready_in     (hreadyout_out),
        .hrdata_out    (hrdata_out),
        .hreadyout_out (hreadyout_out),
        .hresp_out     (),
        .sleep_in      (sleep_in),
        .rc_tick_in    (rc_tick_in),
        .comp_in       (sar_code_out <= target),
        .pin_level_in  (pin_lv),
        .sar_code_out  (sar_code_out),
        .channel_out   (),
        .pin_dir_out   (pin_dir_out),
        .port_read_out (port_read_out),
        .vref_ext_out  (vref_ext_out),
        .sample_out    (sample_out),
        .powered_out   (powered_out),
        .irq_out       (irq_out),
        .wake_out      (wake_out)
    );
    // Core clock at 40 MHz.
    initial
    begin
        mclk_in = 1'b0;
        forever #12.5 mclk_in = ~mclk_in;
    end
    // RC strobe every 32 core cycles, a 1.6 us bit period, and the run time limit.
    always @(posedge mclk_in)
    begin
        rc_cnt     <= (rc_cnt == 5'h1F) ? 5'h00 : rc_cnt + 5'h01;
        rc_tick_in <= (rc_cnt == 5'h1F);
        cycles     <= cycles + 1;
        if (cycles == 20000)
        begin
            err_total = err_total + 1;
            $display("mismatch at %0t: run time limit reached", $time);
            conclude();
        end
    end
    // Prints the counts and the verdict, then ends the run.
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Compares one value and counts the outcome.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks = num_checks + 1;
        if (got !== exp)
        begin
            err_total = err_total + 1;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // Waits for hready sampled high at a rising edge and takes read data at that edge.
    task automatic wait_ready();
        @(posedge mclk_in);
        while (hreadyout_out !== 1'b1)
            @(posedge mclk_in);
        rd = hrdata_out;
    endtask
    // One single word transfer: address phase, then data phase.
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        hsel_in   <= 1'b1;
        haddr_in  <= {22'h000000, idx, 2'b00};
        htrans_in <= 2'b10;
        hwrite_in <= wr;
        wait_ready();
        htrans_in <= 2'b00;
        hwdata_in <= {24'h000000, wd};
        wait_ready();
    endtask
    // Reads one register and compares the whole word.
    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp, input string what);
        bus(1'b0, idx, 8'h00);
        chk(rd, {24'h000000, exp}, what);
    endtask
    // Reset values, an unmapped read and the pin state after reset.
    task automatic t_reset();
        rd_chk(asq_pkg::IDX_CTRL, 8'h00, "control reset");
        rd_chk(asq_pkg::IDX_PCFG, 8'h00, "pin role reset");
        rd_chk(asq_pkg::IDX_IRQ, 8'h00, "irq reset");
        rd_chk(asq_pkg::IDX_DIR, 8'hFF, "direction reset");
        rd_chk(8'h40, 8'h00, "unmapped read");
        chk({24'h000000, pin_dir_out}, 32'h000000FF, "pins as inputs");
        chk({31'h0, powered_out}, 32'h0, "converter off");
        $display("test reset done");
    endtask
    // Every pin role code, with the upper bits written as ones.
    task automatic t_pins();
        logic [7:0] mask;
        for (int c = 0; c < 8; c++)
        begin
            mask = (c < 2) ? 8'hFF : (c < 4) ? 8'h1F : (c < 6) ? 8'h0B : 8'h00;
            pin_lv <= 8'hA5 ^ 8'(c << 5);
            bus(1'b1, asq_pkg::IDX_PCFG, 8'hF8 | 8'(c));
            rd_chk(asq_pkg::IDX_PCFG, 8'(c), "pin role readback");
            rd_chk(asq_pkg::IDX_PORT, pin_lv & ~mask, "port read");
            @(negedge mclk_in);
            chk({31'h0, vref_ext_out}, {31'h0, c[0] && c < 6}, "reference pin");
            @(posedge mclk_in);
        end
        $display("test pin roles done");
    endtask
    // One conversion: length of the busy span and the hold after it, result, flag and wake.
    task automatic t_conv(input logic [1:0] sel, input logic [7:0] tv, input int div,
                          input int dly, input logic sl);
        logic [7:0] on_v;
        logic       ok;
        int         n;
        on_v = {sel, 3'h2, 3'b001};
        target <= tv;
        bus(1'b1, asq_pkg::IDX_CTRL, 8'h00);
        bus(1'b1, asq_pkg::IDX_IRQ, 8'h06);
        bus(1'b1, asq_pkg::IDX_CTRL, on_v | 8'h04);
        rd_chk(asq_pkg::IDX_CTRL, on_v, "start with enable");
        repeat (ACQ_CYC) @(posedge mclk_in);
        bus(1'b1, asq_pkg::IDX_CTRL, on_v | 8'h04);
        sleep_in <= sl;
        n = 0;
        while (sample_out === 1'b1 && n < 20)
        begin
            @(negedge mclk_in);
            n = n + 1;
        end
        n = 0;
        while (sample_out !== 1'b1 && n < 1000)
        begin
            @(negedge mclk_in);
            n = n + 1;
        end
        ok = n >= 22 * div + 1 + dly && n <= 23 * div + 2 + dly;
        chk({31'h0, ok}, 32'h1, "conversion length");
        chk({31'h0, irq_out}, 32'h1, "done request");
        chk({31'h0, wake_out}, {31'h0, sl}, "wake");
        chk({31'h0, powered_out}, {31'h0, ~sl}, "power after done");
        @(posedge mclk_in);
        rd_chk(asq_pkg::IDX_CTRL, on_v, "start cleared");
        rd_chk(asq_pkg::IDX_RESULT, tv, "result");
        rd_chk(asq_pkg::IDX_IRQ, 8'h07, "done flag");
        bus(1'b1, asq_pkg::IDX_IRQ, 8'h06);
        sleep_in <= 1'b0;
        @(negedge mclk_in);
        chk({31'h0, irq_out}, 32'h0, "flag cleared");
        @(posedge mclk_in);
        $display("test conversion done");
    endtask
    // Abort by clearing start or by sleep with a core derived clock.
    task automatic t_abort(input logic slp);
        logic ok;
        int   n;
        target <= 8'h81;
        bus(1'b1, asq_pkg::IDX_RESULT, 8'h3C);
        bus(1'b1, asq_pkg::IDX_IRQ, 8'h00);
        bus(1'b1, asq_pkg::IDX_CTRL, 8'h91);
        repeat (ACQ_CYC) @(posedge mclk_in);
        bus(1'b1, asq_pkg::IDX_CTRL, 8'h95);
        repeat (40) @(posedge mclk_in);
        if (slp)
            sleep_in <= 1'b1;
        else
            bus(1'b1, asq_pkg::IDX_CTRL, 8'h91);
        n = 0;
        @(negedge mclk_in);
        while (sample_out !== 1'b1 && n < 200)
        begin
            @(negedge mclk_in);
            n = n + 1;
        end
        ok = n >= 64 && n <= 66;
        chk({31'h0, ok}, 32'h1, "wait after abort");
        chk({31'h0, powered_out}, {31'h0, ~slp}, "power state");
        @(posedge mclk_in);
        rd_chk(asq_pkg::IDX_RESULT, 8'h3C, "result kept");
        rd_chk(asq_pkg::IDX_IRQ, 8'h00, "no done flag");
        rd_chk(asq_pkg::IDX_CTRL, 8'h91, "enable kept, start cleared");
        sleep_in <= 1'b0;
        $display("test abort done");
    endtask
    // Main sequence, with a second reset in mid-run.
    initial
    begin
        rst_in     = 1'b1;
        hsel_in    = 1'b0;
        haddr_in   = 32'h00000000;
        htrans_in  = 2'b00;
        hwrite_in  = 1'b0;
        hwdata_in  = 32'h00000000;
        sleep_in   = 1'b0;
        target     = 8'h00;
        err_total  = 0;
        num_checks = 0;
        repeat (16) @(posedge mclk_in);
        rst_in <= 1'b0;
        @(posedge mclk_in);
        t_reset();
        t_pins();
        t_conv(asq_pkg::CLK_D2, 8'hC3, 1, 0, 1'b0);
        t_conv(asq_pkg::CLK_D8, 8'h00, 4, 0, 1'b0);
        t_conv(asq_pkg::CLK_D32, 8'hFF, 16, 0, 1'b0);
        t_conv(asq_pkg::CLK_RC, 8'h5A, 32, 4, 1'b1);
        t_abort(1'b0);
        t_abort(1'b1);
        bus(1'b1, asq_pkg::IDX_DIR, 8'h00);
        rst_in <= 1'b1;
        repeat (2) @(posedge mclk_in);
        rst_in <= 1'b0;
        @(posedge mclk_in);
        t_reset();
        conclude();
    end
endmodule
